/* File: rtl/dxc_regs.sv */
// extension control register bank behind the sequencer index/data ports
// How it works
// - write 09h to index C0 arms lock
// - armed then 18h locks; other access disarms
// - lock ends only at reset or disable strobe
// - C8 bit7 plus FF bit4 drives row strobe
// - C8 bit6 enables 1MB linear via valid pin
// - C8 bit4 word dac, needs port 106 bit1
// - C8 bit3 chains planes 2/3 for 9-dot
// - CA gives timing bit 8s with 64K map
// - E0 bit7 selects E8/E9 split offsets
// - E0 bit6 lets port 3B9 decode
// - E0 bit4 allows true word memory access
// - E0 bit3 gives planar-mode 128K map A0000-BFFFF
// - E0 bit2 adds one to offset
// - E0 bit1 plus FE bit7 maps B0000
// - E0 bit0 selects interlaced timing
// - E2 bit0 traps base register port writes
// - E2 bits4-1 trap their own port groups
// - E3 bits5-3 protect overscan, C8, emulation
// - E3 bits2-1 protect crt and dac
// - E3 bit0 protects base ports, not extensions
// - E8/E9 hold bank, page, 4K start fields
// - extensions reachable only after EAh in 06
`timescale 1ns/1ps
`default_nettype none
module dxc_regs
  import dxc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rd_hit_o,
  input wire logic [19:4] host_addr_i,
  input wire logic addr_space_valid_pin_i,
  input wire logic disable_pin_i,
  input wire logic intf16_bit4_i,
  input wire logic fgbg_bit7_i,
  input wire logic port106_bit1_i,
  input wire logic planar_mode_i,
  input wire logic wr_odd_even_i,
  input wire logic chain4_i,
  input wire logic write_mode_bit1_i,
  input wire logic [2:0] rotate_i,
  input wire logic rd_odd_even_i,
  output logic trap_n_o,
  output logic mono_locked_o,
  output dxc_ctl_s ctl_o,
  output logic [3:0] wr_ok_o,
  output logic overscan_wp_o,
  output logic mono_color_sel_o,
  output logic linear_hit_o,
  output logic [15:0] linear_addr_o,
  output logic map128_hit_o,
  output logic map64_hit_o,
  output dxc_bank_s bank_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic disable_d;
  wire logic valid_s = pins_s[0];
  wire logic disable_s = pins_s[1];
  wire logic disable_strobe = disable_s && !disable_d;

  dxc_sync #(.WIDTH(2)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i({disable_pin_i, addr_space_valid_pin_i}),
    .sync_o(pins_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] seq_idx;
  logic [7:0] unlock_val;
  logic [7:0] mono_lock;
  logic [7:0] misc_control_two;
  logic [7:0] horiz_overflow;
  logic [7:0] misc_control_one;
  logic [7:0] interlace_value;
  logic [7:0] trap_control;
  logic [7:0] write_protect_control;
  dxc_bank_s lower_split_bank;
  dxc_bank_s upper_split_bank;
  dxc_lock_e lock_state;
  dxc_lock_e next_lock_state;

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  wire logic at_idx = io_addr_i == P_SEQ_IDX;
  wire logic at_dat = io_addr_i == P_SEQ_DAT;
  wire logic ext_open = unlock_val == UNLOCK_KEY;
  wire logic is_ext_idx = seq_idx[7:6] == 2'b11;
  wire logic ext_wr = io_wr_i && at_dat && ext_open && is_ext_idx;
  wire logic wr_c0 = ext_wr && seq_idx == IDX_MONO_LOCK;
  wire logic wr_c8 = ext_wr && seq_idx == IDX_MISC2;
  wire logic wr_ca = ext_wr && seq_idx == IDX_HOVF;
  wire logic wr_e0 = ext_wr && seq_idx == IDX_MISC1;
  wire logic wr_e1 = ext_wr && seq_idx == IDX_INTERLACE_VALUE;
  wire logic wr_e2 = ext_wr && seq_idx == IDX_TRAP;
  wire logic wr_e3 = ext_wr && seq_idx == IDX_WP;
  wire logic wr_e8 = ext_wr && seq_idx == IDX_LSPLIT;
  wire logic wr_e9 = ext_wr && seq_idx == IDX_USPLIT;
  wire logic wr_sr6 = io_wr_i && at_dat && seq_idx == IDX_UNLOCK;
  wire logic c8_c9_idx = seq_idx == IDX_MISC2 || seq_idx == IDX_LIN_OFS;

  // port groups for traps and protection
  wire logic port_dac = io_addr_i >= P_DAC_FIRST && io_addr_i <= P_DAC_LAST;
  wire logic port_crt = io_addr_i == P_CRT_MONO_IDX || io_addr_i == P_CRT_MONO_DAT
                     || io_addr_i == P_CRT_COLOR_IDX || io_addr_i == P_CRT_COLOR_DAT;
  wire logic port_emu_wp = io_addr_i == P_EMU_MONO_MODE || io_addr_i == P_EMU_MONO_CFG
                        || io_addr_i == P_EMU_COLOR_MODE || io_addr_i == P_EMU_COLOR_SEL;
  wire logic port_emu = port_emu_wp || io_addr_i == P_EMU_COLOR_EXT;
  wire logic port_base = io_addr_i == P_ATTR || io_addr_i == P_MISC_OUT
                      || io_addr_i == P_ENABLE || io_addr_i == P_GFX_IDX
                      || io_addr_i == P_GFX_DAT || at_idx || at_dat
                      || io_addr_i == P_FEAT_MONO || io_addr_i == P_FEAT_COLOR;
  wire logic port_ext = at_idx || (at_dat && c8_c9_idx);
  // sequencer data writes to 06 and to extensions stay writable
  wire logic base_exempt = at_dat && (seq_idx == IDX_UNLOCK || is_ext_idx);

  // ----------------------------------------------------------------
  // trap strobe
  // ----------------------------------------------------------------
  wire logic [4:0] trap_hit = {port_ext, port_emu, port_crt, port_dac, port_base};
  wire logic next_trap_n = !(io_wr_i && |(trap_hit & trap_control[4:0]));

  // ----------------------------------------------------------------
  // write protection of other register groups
  // ----------------------------------------------------------------
  wire logic [3:0] next_wr_ok = {
    io_wr_i && port_emu_wp && !write_protect_control[GRP_EMU],
    io_wr_i && port_crt && !write_protect_control[GRP_CRT],
    io_wr_i && port_dac && !write_protect_control[GRP_DAC],
    io_wr_i && port_base && (base_exempt || !write_protect_control[GRP_BASE])
  };
  wire logic c8_open = !write_protect_control[GRP_EXT];

  // ----------------------------------------------------------------
  // monochrome lock sequence
  // ----------------------------------------------------------------
  wire logic lock_write = wr_c0 && io_wdata_i == LOCK_KEY;
  wire logic arm_write = wr_c0 && io_wdata_i == ARM_KEY;
  // the index write that selects C0 is part of the arming access
  wire logic idx_to_c0 = io_wr_i && at_idx && io_wdata_i == IDX_MONO_LOCK;
  wire logic other_access = (io_rd_i || io_wr_i) && !lock_write && !arm_write && !idx_to_c0;

  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      DXC_IDLE: begin
        if (arm_write) begin
          next_lock_state = DXC_ARMED;
        end
      end
      DXC_ARMED: begin
        if (lock_write) begin
          next_lock_state = DXC_LOCKED;
        end else if (other_access) begin
          next_lock_state = DXC_IDLE;
        end
      end
      DXC_LOCKED: begin
        if (disable_strobe) begin
          next_lock_state = DXC_IDLE;
        end
      end
      default: begin
        next_lock_state = DXC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // derived controls
  // ----------------------------------------------------------------
  wire logic word_wr = (wr_odd_even_i || chain4_i) && !write_mode_bit1_i && rotate_i == 3'h0;
  wire logic word_rd = rd_odd_even_i || chain4_i;
  dxc_ctl_s next_ctl;
  assign next_ctl.extra_row_strobe_en = misc_control_two[C8_XRAS] && intf16_bit4_i;
  assign next_ctl.word_dac = misc_control_two[C8_WORD_DAC] && port106_bit1_i;
  assign next_ctl.nine_dot = misc_control_two[C8_NINE_DOT];
  assign next_ctl.hovf = misc_control_one[E0_MAP64] ? horiz_overflow[4:0] : 5'h00;
  assign next_ctl.interlace = misc_control_one[E0_INTERLACE];
  assign next_ctl.byte_offset_add = misc_control_one[E0_BYTE_OFS];
  assign next_ctl.word_wr_ok = misc_control_one[E0_WORD] && word_wr;
  assign next_ctl.word_rd_ok = misc_control_one[E0_WORD] && word_rd;
  assign next_ctl.interlace_value_nibble = interlace_value[7];
  assign next_ctl.interlace_value_char = interlace_value[6:0];

  // memory map decode on host address
  wire logic next_linear = misc_control_two[C8_LINEAR] && valid_s;
  wire logic next_map128 = misc_control_one[E0_MAP128] && planar_mode_i
                        && host_addr_i[19:17] == 3'h5;
  wire logic next_map64 = misc_control_one[E0_MAP64] && fgbg_bit7_i
                       && host_addr_i[19:16] == 4'hB;
  wire dxc_bank_s next_bank = !misc_control_one[E0_SPLIT] ? '0 :
                              host_addr_i[15] ? upper_split_bank : lower_split_bank;
  wire logic next_mono_color = (io_wr_i || io_rd_i) && io_addr_i == P_MONO_COLOR
                            && misc_control_one[E0_MONO_COLOR];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] ext_rdata;
  always_comb begin
    ext_rdata = 8'h00;
    unique case (seq_idx)
      IDX_MONO_LOCK: ext_rdata = mono_lock;
      IDX_MISC2: ext_rdata = misc_control_two;
      IDX_HOVF: ext_rdata = horiz_overflow;
      IDX_MISC1: ext_rdata = misc_control_one;
      IDX_INTERLACE_VALUE: ext_rdata = interlace_value;
      IDX_TRAP: ext_rdata = trap_control;
      IDX_WP: ext_rdata = write_protect_control;
      IDX_LSPLIT: ext_rdata = lower_split_bank;
      IDX_USPLIT: ext_rdata = upper_split_bank;
      default: ext_rdata = 8'h00;
    endcase
  end
  wire logic rd_ext = at_dat && ext_open && is_ext_idx;
  wire logic rd_sr6 = at_dat && seq_idx == IDX_UNLOCK;
  wire logic next_rd_hit = io_rd_i && (at_idx || rd_ext || rd_sr6);
  wire logic [7:0] next_rdata = !io_rd_i ? 8'h00 : at_idx ? seq_idx : rd_sr6 ? unlock_val :
                                rd_ext ? ext_rdata : 8'h00;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      seq_idx <= REG_RESET;
      unlock_val <= REG_RESET;
      mono_lock <= REG_RESET;
      misc_control_two <= REG_RESET;
      horiz_overflow <= REG_RESET;
      misc_control_one <= REG_RESET;
      interlace_value <= REG_RESET;
      trap_control <= REG_RESET;
      write_protect_control <= REG_RESET;
      lower_split_bank <= '0;
      upper_split_bank <= '0;
    end else begin
      if (io_wr_i && at_idx) seq_idx <= io_wdata_i;
      if (wr_sr6) unlock_val <= io_wdata_i;
      if (wr_c0) mono_lock <= io_wdata_i;
      if (wr_c8 && c8_open) misc_control_two <= io_wdata_i & MISC2_MASK;
      if (wr_ca) horiz_overflow <= io_wdata_i & HOVF_MASK;
      if (wr_e0) misc_control_one <= io_wdata_i;
      if (wr_e1) interlace_value <= io_wdata_i;
      if (wr_e2) trap_control <= io_wdata_i & TRAP_MASK;
      if (wr_e3) write_protect_control <= io_wdata_i & WP_MASK;
      if (wr_e8) lower_split_bank <= dxc_bank_s'(io_wdata_i);
      if (wr_e9) upper_split_bank <= dxc_bank_s'(io_wdata_i);
    end
  end

  // state and output flops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_state <= DXC_IDLE;
      disable_d <= 1'b0;
      trap_n_o <= 1'b1;
      wr_ok_o <= 4'h0;
      ctl_o <= '0;
      bank_o <= '0;
      io_rdata_o <= 8'h00;
      io_rd_hit_o <= 1'b0;
    end else begin
      lock_state <= next_lock_state;
      disable_d <= disable_s;
      trap_n_o <= next_trap_n;
      wr_ok_o <= next_wr_ok;
      ctl_o <= next_ctl;
      bank_o <= next_bank;
      io_rdata_o <= next_rdata;
      io_rd_hit_o <= next_rd_hit;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mono_locked_o <= 1'b0;
      overscan_wp_o <= 1'b0;
      mono_color_sel_o <= 1'b0;
      linear_hit_o <= 1'b0;
      linear_addr_o <= 16'h0000;
      map128_hit_o <= 1'b0;
      map64_hit_o <= 1'b0;
    end else begin
      mono_locked_o <= next_lock_state == DXC_LOCKED;
      overscan_wp_o <= write_protect_control[WP_OVERSCAN];
      mono_color_sel_o <= next_mono_color;
      linear_hit_o <= next_linear;
      linear_addr_o <= next_linear ? host_addr_i : 16'h0000;
      map128_hit_o <= next_map128;
      map64_hit_o <= next_map64;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_lock_from_armed: assert property (
    lock_state == DXC_ARMED && lock_write |=> mono_locked_o && lock_state == DXC_LOCKED)
    else $error("armed lock write did not lock");
  a_lock_arms_first: assert property (
    lock_state == DXC_IDLE && arm_write |=> lock_state == DXC_ARMED)
    else $error("arm write did not arm the lock");
  a_disarm_other: assert property (
    lock_state == DXC_ARMED && other_access |=> lock_state == DXC_IDLE)
    else $error("other access did not disarm");
  a_lock_holds: assert property (
    mono_locked_o && !disable_strobe |=> mono_locked_o)
    else $error("lock released without disable strobe");
  a_trap_dac_pulse: assert property (
    io_wr_i && port_dac && trap_control[GRP_DAC] |=> !trap_n_o ##1 (trap_n_o || $past(io_wr_i)))
    else $error("dac trap pulse wrong");
  a_trap_quiet: assert property (
    !io_wr_i |=> trap_n_o)
    else $error("trap pulse without a write");
  a_c8_protect: assert property (
    wr_c8 && write_protect_control[GRP_EXT] |=> $stable(misc_control_two))
    else $error("protected C8 changed");
  a_locked_ext_gate: assert property (
    io_wr_i && at_dat && seq_idx == IDX_MISC2 && !ext_open |=> $stable(misc_control_two))
    else $error("extension written while closed");
  a_dac_wp_block: assert property (
    io_wr_i && port_dac && write_protect_control[GRP_DAC] |=> !wr_ok_o[GRP_DAC])
    else $error("protected dac write accepted");
  a_split_upper: assert property (
    misc_control_one[E0_SPLIT] && host_addr_i[15] |=> bank_o == $past(upper_split_bank))
    else $error("upper split offset not selected");
endmodule
`default_nettype wire

/* File: shared/dxc_pkg.sv */
// constants and carrier types for the display extension control bank
package dxc_pkg;

  // ----------------------------------------------------------------
  // host i/o port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] P_SEQ_IDX = 16'h03C4;
  localparam logic [15:0] P_SEQ_DAT = 16'h03C5;
  localparam logic [15:0] P_MONO_COLOR = 16'h03B9;
  localparam logic [15:0] P_ATTR = 16'h03C0;
  localparam logic [15:0] P_MISC_OUT = 16'h03C2;
  localparam logic [15:0] P_ENABLE = 16'h03C3;
  localparam logic [15:0] P_GFX_IDX = 16'h03CE;
  localparam logic [15:0] P_GFX_DAT = 16'h03CF;
  localparam logic [15:0] P_FEAT_MONO = 16'h03BA;
  localparam logic [15:0] P_FEAT_COLOR = 16'h03DA;
  localparam logic [15:0] P_DAC_FIRST = 16'h03C6;
  localparam logic [15:0] P_DAC_LAST = 16'h03C9;
  localparam logic [15:0] P_CRT_MONO_IDX = 16'h03B4;
  localparam logic [15:0] P_CRT_MONO_DAT = 16'h03B5;
  localparam logic [15:0] P_CRT_COLOR_IDX = 16'h03D4;
  localparam logic [15:0] P_CRT_COLOR_DAT = 16'h03D5;
  localparam logic [15:0] P_EMU_MONO_MODE = 16'h03B8;
  localparam logic [15:0] P_EMU_MONO_CFG = 16'h03BF;
  localparam logic [15:0] P_EMU_COLOR_MODE = 16'h03D8;
  localparam logic [15:0] P_EMU_COLOR_SEL = 16'h03D9;
  localparam logic [15:0] P_EMU_COLOR_EXT = 16'h03DE;

  // ----------------------------------------------------------------
  // extension indices behind the sequencer data port
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_UNLOCK = 8'h06;
  localparam logic [7:0] IDX_MONO_LOCK = 8'hC0;
  localparam logic [7:0] IDX_MISC2 = 8'hC8;
  localparam logic [7:0] IDX_LIN_OFS = 8'hC9;
  localparam logic [7:0] IDX_HOVF = 8'hCA;
  localparam logic [7:0] IDX_MISC1 = 8'hE0;
  localparam logic [7:0] IDX_INTERLACE_VALUE = 8'hE1;
  localparam logic [7:0] IDX_TRAP = 8'hE2;
  localparam logic [7:0] IDX_WP = 8'hE3;
  localparam logic [7:0] IDX_LSPLIT = 8'hE8;
  localparam logic [7:0] IDX_USPLIT = 8'hE9;
  localparam logic [7:0] IDX_SWITCH_SAMPLE_STROBE = 8'hEA;

  // ----------------------------------------------------------------
  // key values, writable masks, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY = 8'hEA;
  localparam logic [7:0] ARM_KEY = 8'h09;
  localparam logic [7:0] LOCK_KEY = 8'h18;
  localparam logic [7:0] MISC2_MASK = 8'hD8;
  localparam logic [7:0] HOVF_MASK = 8'h1F;
  localparam logic [7:0] TRAP_MASK = 8'h1F;
  localparam logic [7:0] WP_MASK = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C8_XRAS = 7;
  localparam int C8_LINEAR = 6;
  localparam int C8_WORD_DAC = 4;
  localparam int C8_NINE_DOT = 3;
  localparam int E0_SPLIT = 7;
  localparam int E0_MONO_COLOR = 6;
  localparam int E0_WORD = 4;
  localparam int E0_MAP128 = 3;
  localparam int E0_BYTE_OFS = 2;
  localparam int E0_MAP64 = 1;
  localparam int E0_INTERLACE = 0;
  localparam int GRP_BASE = 0;
  localparam int GRP_DAC = 1;
  localparam int GRP_CRT = 2;
  localparam int GRP_EMU = 3;
  localparam int GRP_EXT = 4;
  localparam int WP_OVERSCAN = 5;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DXC_IDLE = 3'b001,
    DXC_ARMED = 3'b010,
    DXC_LOCKED = 3'b100
  } dxc_lock_e;

  typedef struct packed {
    logic [1:0] cpu_bank;
    logic page;
    logic ext_page;
    logic [3:0] start_4k;
  } dxc_bank_s;

  typedef struct packed {
    logic extra_row_strobe_en;
    logic word_dac;
    logic nine_dot;
    logic [4:0] hovf;
    logic interlace;
    logic byte_offset_add;
    logic word_wr_ok;
    logic word_rd_ok;
    logic interlace_value_nibble;
    logic [6:0] interlace_value_char;
  } dxc_ctl_s;

endpackage

/* File: rtl/dxc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dxc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // elaboration check on the width
  if (WIDTH < 1) begin : g_bad_width
    $error("dxc_sync width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: verification/dxc_host.sv */
// host i/o bus model that drives the extension bank ports
`timescale 1ns/1ps
`default_nettype none
module dxc_host (
  input wire logic core_clk_i,
  input wire logic [7:0] io_rdata_i,
  output logic [15:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o
);
  // idle bus from time zero
  initial begin
    io_addr_o = 16'h0000;
    io_wr_o = 1'h0;
    io_rd_o = 1'h0;
    io_wdata_o = 8'h00;
  end
  // byte write, held up to the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'h1;
    @(posedge core_clk_i);
    io_wr_o <= 1'h0;
    io_wdata_o <= ~d; // released data must not linger
  endtask
  // byte read, data taken the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    io_addr_o <= a;
    io_rd_o <= 1'h1;
    @(posedge core_clk_i);
    io_rd_o <= 1'h0;
    @(negedge core_clk_i);
    d = io_rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: verification/display_ext_control_regs_tb.sv */
// self-checking bench for the extension control bank
`timescale 1ns/1ps
`default_nettype none
module display_ext_control_regs_tb;
  import dxc_pkg::*;
  logic core_clk_i, rst_i, asv, dis, i16, fgbg, p106, wroe, rdoe, io_wr, io_rd;
  logic trap_n, locked, lin_hit, m128, m64, ovs, mcs, rd_hit, rh, plan, ch4, wm1;
  logic [15:0] haddr, io_addr, lin_addr;
  logic [7:0] io_wdata, io_rdata, rv;
  logic [3:0] wr_ok;
  logic [2:0] rot;
  dxc_ctl_s ctl;
  dxc_bank_s bank;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  dxc_host host (.core_clk_i(core_clk_i), .io_rdata_i(io_rdata), .io_addr_o(io_addr),
    .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata));
  dxc_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rd_hit_o(rd_hit),
    .host_addr_i(haddr), .addr_space_valid_pin_i(asv), .disable_pin_i(dis),
    .intf16_bit4_i(i16), .fgbg_bit7_i(fgbg), .port106_bit1_i(p106), .planar_mode_i(plan),
    .wr_odd_even_i(wroe), .chain4_i(ch4), .write_mode_bit1_i(wm1), .rotate_i(rot),
    .rd_odd_even_i(rdoe), .trap_n_o(trap_n), .mono_locked_o(locked), .ctl_o(ctl),
    .wr_ok_o(wr_ok), .overscan_wp_o(ovs), .mono_color_sel_o(mcs), .linear_hit_o(lin_hit),
    .linear_addr_o(lin_addr), .map128_hit_o(m128), .map64_hit_o(m64), .bank_o(bank));
  // clock and hang guard
  initial begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // indexed access through the sequencer port pair
  task automatic xw(input logic [7:0] i, input logic [7:0] d);
    host.wr(P_SEQ_IDX, i);
    host.wr(P_SEQ_DAT, d);
  endtask
  task automatic xr(input logic [7:0] i, input logic [7:0] e);
    host.wr(P_SEQ_IDX, i);
    host.rd(P_SEQ_DAT, rv);
    rh = rd_hit;
    chk("ext reg", {16'h0, e}, {16'h0, rv});
  endtask
  // one port write, then trap pin or accept pulse
  task automatic tw(input logic [15:0] a, input logic e);
    host.wr(a, 8'h00);
    @(negedge core_clk_i);
    chk("trap_n", {23'h0, e}, {23'h0, trap_n});
  endtask
  task automatic okw(input logic [15:0] a, input int b, input logic e);
    host.wr(a, 8'h00);
    @(negedge core_clk_i);
    chk("wr_ok", {23'h0, e}, {23'h0, wr_ok[b]});
  endtask
  task automatic t_closed();
    xw(IDX_MISC2, 8'hD8);
    xr(IDX_MISC2, 8'h00);
    chk("rd_hit", 24'h0, {23'h0, rh});
    xw(IDX_UNLOCK, UNLOCK_KEY);
    xr(IDX_MISC2, 8'h00);
    chk("rd_hit", 24'h1, {23'h0, rh});
  endtask
  task automatic t_regs();
    logic [7:0] ix [6] = '{IDX_MISC2, IDX_HOVF, IDX_INTERLACE_VALUE, IDX_TRAP, IDX_WP, IDX_LSPLIT};
    logic [7:0] mk [6] = '{MISC2_MASK, HOVF_MASK, 8'hFF, TRAP_MASK, WP_MASK, 8'hFF};
    for (int k = 0; k < 6; k++) begin
      xr(ix[k], REG_RESET);
      xw(ix[k], 8'hFF);
      xr(ix[k], mk[k]);
      xw(ix[k], 8'h00);
    end
  endtask
  task automatic t_lock();
    xw(IDX_MONO_LOCK, ARM_KEY);
    xr(IDX_MONO_LOCK, ARM_KEY);
    host.wr(P_SEQ_DAT, LOCK_KEY);
    @(negedge core_clk_i);
    chk("locked", 24'h0, {23'h0, locked});
    host.wr(P_SEQ_DAT, ARM_KEY);
    host.wr(P_SEQ_DAT, LOCK_KEY);
    @(negedge core_clk_i);
    chk("locked", 24'h1, {23'h0, locked});
    xr(IDX_HOVF, 8'h00);
    chk("locked", 24'h1, {23'h0, locked});
    @(posedge core_clk_i);
    dis <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    dis <= 1'h0;
    @(negedge core_clk_i);
    chk("locked", 24'h0, {23'h0, locked});
  endtask
  task automatic t_trap();
    xw(IDX_TRAP, 8'h01);
    tw(P_ATTR, 1'h0);
    @(negedge core_clk_i);
    chk("trap_n", 24'h1, {23'h0, trap_n});
    xw(IDX_TRAP, 8'h02);
    tw(P_DAC_LAST, 1'h0);
    tw(P_ATTR, 1'h1);
    xw(IDX_TRAP, 8'h00);
  endtask
  task automatic t_prot();
    xw(IDX_WP, 8'h30);
    xw(IDX_MISC2, 8'hD8);
    xr(IDX_MISC2, 8'h00);
    chk("overscan", 24'h1, {23'h0, ovs});
    xw(IDX_WP, 8'h0E);
    okw(P_CRT_COLOR_DAT, 2, 1'h0);
    okw(P_DAC_FIRST, 1, 1'h0);
    okw(P_EMU_COLOR_MODE, 3, 1'h0);
    chk("overscan", 24'h0, {23'h0, ovs});
    xw(IDX_WP, 8'h01);
    okw(P_ATTR, 0, 1'h0);
    xw(IDX_INTERLACE_VALUE, 8'h85);
    xr(IDX_INTERLACE_VALUE, 8'h85);
    xw(IDX_WP, 8'h00);
    okw(P_CRT_COLOR_DAT, 2, 1'h1);
    okw(P_DAC_FIRST, 1, 1'h1);
    okw(P_EMU_COLOR_MODE, 3, 1'h1);
  endtask
  task automatic t_modes();
    host.wr(P_MONO_COLOR, 8'h00);
    @(negedge core_clk_i);
    chk("mono_color", 24'h0, {23'h0, mcs});
    @(posedge core_clk_i);
    {i16, p106, wroe, rdoe, fgbg, asv} <= 6'h3F;
    haddr <= 16'hA800;
    xw(IDX_LSPLIT, 8'hA5);
    xw(IDX_USPLIT, 8'h3C);
    xw(IDX_MISC2, 8'hD8);
    xw(IDX_HOVF, 8'h1F);
    xw(IDX_MISC1, 8'h9F);
    repeat (4) @(negedge core_clk_i);
    chk("ctl", 24'hFFF85, {4'h0, ctl});
    chk("linear", 24'h1A800, {7'h0, lin_hit, lin_addr});
    chk("bank", 24'h13C, {15'h0, m128, bank});
    // 64K map window, planar off, chain-4 reads, write mode bit 1 set
    @(posedge core_clk_i);
    haddr <= 16'hB000;
    {plan, wm1, rdoe, ch4} <= 4'h5;
    repeat (2) @(negedge core_clk_i);
    chk("maps", 24'h2, {22'h0, m64, m128});
    chk("ctl", 24'hFFD85, {4'h0, ctl});
    @(posedge core_clk_i);
    haddr <= 16'h2000;
    xw(IDX_MISC1, 8'hC0);
    repeat (4) @(negedge core_clk_i);
    chk("bank", 24'h0A5, {15'h0, m128, bank});
    chk("ctl", 24'hE0085, {4'h0, ctl});
    host.wr(P_MONO_COLOR, 8'h00);
    @(negedge core_clk_i);
    chk("mono_color", 24'h1, {23'h0, mcs});
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_i = 1'h1;
    {asv, dis, i16, fgbg, p106, wroe, rdoe} = 7'h00;
    haddr = 16'h0000;
    rot = 3'h0;
    {plan, ch4, wm1} = 3'h4;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'h0;
    t_closed();
    t_regs();
    t_lock();
    t_trap();
    t_prot();
    t_modes();
    results();
  end
endmodule
`default_nettype wire
